// >>> core/rps_regs.svh
`ifndef RPS_REGS_SVH
`define RPS_REGS_SVH
// Per-link register offsets within a page
`define RPS_OFF_PL_STAT 8'hCD
`define RPS_OFF_PL_ACTL 8'hCE
`define RPS_OFF_PL_DATA 8'hCF
`define RPS_OFF_PL_CFG 8'hD0
`define RPS_OFF_PL_ENA 8'hD1
`define RPS_OFF_SG_CFG 8'hD2
`define RPS_OFF_SG_STAT 8'hD3
`define RPS_OFF_SG_ACTL 8'hD4
`define RPS_OFF_SG_DATA 8'hD5
`define RPS_OFF_CF0 8'hD6
`define RPS_OFF_CF1 8'hD7
`define RPS_OFF_CF2 8'hD8
// Reset values and writable masks
`define RPS_RST_PL_CFG 8'h80
`define RPS_MSK_PL_CFG 8'hC7
`define RPS_RST_PL_ENA 8'h00
`define RPS_MSK_PL_ENA 8'h0F
`define RPS_RST_SG_CFG 8'h01
`define RPS_MSK_SG_CFG 8'h0F
`define RPS_RST_SG_EN 1'h1
// Field positions
`define RPS_B_SNAP 7
`define RPS_B_GTRK 6
`define RPS_B_SIG_POSITION_SEL 3
`define RPS_B_FIX 2
`define RPS_B_POL 1
`define RPS_B_PAYLOAD_CTRL_ENABLE 0
`define RPS_B_FREEZE 3
`define RPS_B_DEB 2
`define RPS_B_SIG_CHANGE_IRQ_EN 1
`define RPS_B_SIG_STATE_FORMAT 0
`define RPS_B_DIR 7
`define RPS_B_XEN 4
`define RPS_B_STRK 4
// Indirect address ranges and table bases
`define RPS_IA_LO0 7'h01
`define RPS_IA_HI0 7'h18
`define RPS_IA_LO1 7'h21
`define RPS_IA_HI1 7'h38
`define RPS_IA_LO2 7'h41
`define RPS_IA_HI2 7'h58
`define RPS_BASE_DATA_TRUNK_CODE 7'h18
`define RPS_BASE_STRK 7'h30
`define RPS_PL_WORDS 72
`define RPS_CHANS 24
`define RPS_LINKS 4
// Frame formats and signaling frame numbers
`define RPS_FMT_SF 2'h0
`define RPS_FMT_DM 2'h3
`define RPS_FRM_FIRST 5'h01
`define RPS_FRM_6 5'h06
`define RPS_FRM_12 5'h0C
`define RPS_FRM_18 5'h12
`define RPS_FRM_24 5'h18
// Substitution codes and milliwatt sequences
`define RPS_SUB_DATA_TRUNK_CODE 3'h1
`define RPS_SUB_ALAW 3'h2
`define RPS_SUB_MULAW 3'h3
`define RPS_PAT_ALAW 64'h34212134B4A1A1B4
`define RPS_PAT_MULAW 64'h1E0B0B1E9E8B8B9E
`endif

// >>> core/rps_pkg.sv
package rps_pkg;
  // Indirect access window state
  typedef enum logic {
    RPS_IDLE = 1'b0,
    RPS_BUSY = 1'b1
  } rps_acc_state_t;

  // One received channel time slot from the framer
  typedef struct packed {
    logic valid;
    logic in_sync;
    logic [1:0] fmt;
    logic [4:0] frame;
    logic [4:0] chan;
    logic [7:0] data;
    logic sig_bit;
  } rps_sig_in_t;

  // One processed time slot toward the system side
  typedef struct packed {
    logic valid;
    logic [4:0] chan;
    logic [7:0] data;
    logic [3:0] rx_sig_out;
  } rps_sig_out_t;
endpackage

// >>> core/rps_ctrl.sv
// Functional notes
// - Payload read: control with direction set returns byte
// - Payload addresses 01-18, 21-38, 41-58 hex
// - Extraction addresses only 01-18 hex
// - Extraction read returns byte in window
// - Busy high during indirect access; refuse others
// - Snapshot locks first frame signaling per multiframe
// - Trunk code replaces signaling globally or per channel
// - Global substitution: channel, trunk, A-law, mu-law
// - Position bit keeps AB at nibble top and clears CD in non-SF formats
// - Signaling fix forces ABCD to polarity
// - Control enable gates trunk, fix and substitution, not position select
// - Freeze holds extracted signaling value
// - De-bounce needs two identical codewords
// - Interrupt when enabled and any flag set
// - 4-state AB or 16-state ABCD extraction
// - Flag set on channel signaling change
// - Flags clear only on written one
// - Flag registers map channels 1-8, 9-16
// - Four links, one register page each
// - Third flag register covers channels 17-24
// - Extraction entries hold signaling and enable
`include "rps_regs.svh"

module rps_ctrl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input rps_pkg::rps_sig_in_t sig_in [`RPS_LINKS],
  output rps_pkg::rps_sig_out_t sig_out [`RPS_LINKS],
  output logic sig_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Map a payload indirect address to a table index, bit 7 marks a hit
  // The three ranges are packed into one table so that one array serves
  // substitution codes, data trunk bytes and trunk signaling entries.
  // Addresses in the gaps between ranges miss and are never stored.
  function automatic logic [7:0] rps_pl_index(input logic [6:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a >= `RPS_IA_LO0 && a <= `RPS_IA_HI0) begin
      r = {1'b1, 7'(a - `RPS_IA_LO0)};
    end else if (a >= `RPS_IA_LO1 && a <= `RPS_IA_HI1) begin
      r = {1'b1, 7'(a - `RPS_IA_LO1 + `RPS_BASE_DATA_TRUNK_CODE)};
    end else if (a >= `RPS_IA_LO2 && a <= `RPS_IA_HI2) begin
      r = {1'b1, 7'(a - `RPS_IA_LO2 + `RPS_BASE_STRK)};
    end
    return r;
  endfunction

  // Milliwatt byte for the given phase of the 8-byte sequence
  // The phase follows the frame number, so the pattern restarts with
  // every eighth frame rather than running on a free counter.
  function automatic logic [7:0] rps_mw(input logic mu, input logic [2:0] ph);
    logic [63:0] pat;
    pat = mu ? `RPS_PAT_MULAW : `RPS_PAT_ALAW;
    return pat[6'(7 - ph) * 8 +: 8];
  endfunction

  logic [7:0] link_rd [`RPS_LINKS];
  logic [`RPS_LINKS-1:0] link_irq;
  logic [7:0] next_rdata;

  ////////////////////////////////////////////////////////////////////////////
  for (genvar l = 0; l < `RPS_LINKS; l++) begin : g_link
    logic sel;
    rps_pkg::rps_sig_in_t s;
    assign sel = addr[9:8] == 2'(l);
    assign s = sig_in[l];

    logic [7:0] pl_cfg, pl_ena, sg_cfg, pl_actl, pl_data, sg_actl, sg_data;
    logic [7:0] next_pl_cfg, next_pl_ena, next_sg_cfg, next_pl_actl;
    logic [7:0] next_pl_data, next_sg_actl, next_sg_data;
    rps_pkg::rps_acc_state_t pl_st, sg_st, next_pl_st, next_sg_st;
    logic [7:0] pl_mem [`RPS_PL_WORDS];
    logic [7:0] next_pl_mem [`RPS_PL_WORDS];
    logic [`RPS_CHANS-1:0] sg_en, next_sg_en, sig_change_flag, next_sig_change_flag;
    logic [3:0] sg_abcd [`RPS_CHANS];
    logic [3:0] sg_last [`RPS_CHANS];
    logic [3:0] sg_acc [`RPS_CHANS];
    logic [3:0] sg_snap [`RPS_CHANS];
    logic [3:0] next_sg_abcd [`RPS_CHANS];
    logic [3:0] next_sg_last [`RPS_CHANS];
    logic [3:0] next_sg_acc [`RPS_CHANS];
    logic [3:0] next_sg_snap [`RPS_CHANS];
    rps_pkg::rps_sig_out_t out_q, next_out;
    logic sync_ok, long_mf, ch_ok;
    logic [4:0] ch;

    // Signaling is only trusted while a signaling-capable format is locked
    // Out-of-sync slots still pass their payload, but leave the
    // accumulators, stored codewords and change flags untouched.
    assign sync_ok = s.in_sync && (s.fmt != `RPS_FMT_DM);
    assign long_mf = s.fmt != `RPS_FMT_SF;
    assign ch = s.chan;
    assign ch_ok = s.valid && (ch < 5'(`RPS_CHANS));

    //////////////////////////////////////////////////////////////////////////
    // Direct registers and the two indirect access windows
    always_comb begin
      logic [7:0] pi;
      logic [4:0] si;
      pi = rps_pl_index(pl_actl[6:0]);
      si = 5'(sg_actl[6:0] - `RPS_IA_LO0);
      next_pl_cfg = pl_cfg;
      next_pl_ena = pl_ena;
      next_sg_cfg = sg_cfg;
      next_pl_actl = pl_actl;
      next_pl_data = pl_data;
      next_sg_actl = sg_actl;
      next_sg_data = sg_data;
      next_pl_st = pl_st;
      next_sg_st = sg_st;
      next_pl_mem = pl_mem;
      next_sg_en = sg_en;
      if (wr && sel) begin
        unique case (addr[7:0])
          `RPS_OFF_PL_CFG: next_pl_cfg = wdata & `RPS_MSK_PL_CFG;
          `RPS_OFF_PL_ENA: next_pl_ena = wdata & `RPS_MSK_PL_ENA;
          `RPS_OFF_SG_CFG: next_sg_cfg = wdata & `RPS_MSK_SG_CFG;
          `RPS_OFF_PL_DATA: next_pl_data = wdata;
          `RPS_OFF_SG_DATA: next_sg_data = wdata;
          `RPS_OFF_PL_ACTL: begin
            // A new command while busy is dropped
            if (pl_st == rps_pkg::RPS_IDLE) begin
              next_pl_actl = wdata;
              next_pl_st = rps_pkg::RPS_BUSY;
            end
          end
          `RPS_OFF_SG_ACTL: begin
            if (sg_st == rps_pkg::RPS_IDLE) begin
              next_sg_actl = wdata;
              next_sg_st = rps_pkg::RPS_BUSY;
            end
          end
          default: begin
          end
        endcase
      end
      // The access completes in the busy cycle; its result wins the window
      if (pl_st == rps_pkg::RPS_BUSY) begin
        next_pl_st = rps_pkg::RPS_IDLE;
        if (pl_actl[`RPS_B_DIR]) begin
          next_pl_data = pi[7] ? pl_mem[pi[6:0]] : 8'h00;
        end else if (pi[7]) begin
          next_pl_mem[pi[6:0]] = pl_data;
        end
      end
      if (sg_st == rps_pkg::RPS_BUSY) begin
        next_sg_st = rps_pkg::RPS_IDLE;
        // Out-of-range addresses read zero and write nothing
        if (sg_actl[6:0] >= `RPS_IA_LO0 && sg_actl[6:0] <= `RPS_IA_HI0) begin
          if (sg_actl[`RPS_B_DIR]) begin
            next_sg_data = {3'h0, sg_en[si], sg_abcd[si]};
          end else begin
            next_sg_en[si] = sg_data[`RPS_B_XEN];
          end
        end else if (sg_actl[`RPS_B_DIR]) begin
          next_sg_data = 8'h00;
        end
      end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        pl_cfg <= `RPS_RST_PL_CFG;
        pl_ena <= `RPS_RST_PL_ENA;
        sg_cfg <= `RPS_RST_SG_CFG;
        pl_actl <= 8'h00;
        pl_data <= 8'h00;
        sg_actl <= 8'h00;
        sg_data <= 8'h00;
        pl_st <= rps_pkg::RPS_IDLE;
        sg_st <= rps_pkg::RPS_IDLE;
        sg_en <= {`RPS_CHANS{`RPS_RST_SG_EN}};
        for (int i = 0; i < `RPS_PL_WORDS; i++) begin
          pl_mem[i] <= 8'h00;
        end
      end else begin
        pl_cfg <= next_pl_cfg;
        pl_ena <= next_pl_ena;
        sg_cfg <= next_sg_cfg;
        pl_actl <= next_pl_actl;
        pl_data <= next_pl_data;
        sg_actl <= next_sg_actl;
        sg_data <= next_sg_data;
        pl_st <= next_pl_st;
        sg_st <= next_sg_st;
        sg_en <= next_sg_en;
        pl_mem <= next_pl_mem;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Signaling extraction, de-bounce, freeze and change flags
    // A codeword is judged only when its multiframe completes; partial
    // words never reach the stored value, so a lost frame cannot
    // raise a false change flag.
    always_comb begin
      logic [3:0] acc;
      logic sixteen;
      logic done;
      logic [`RPS_CHANS-1:0] setf, clrf;
      acc = 4'h0;
      sixteen = long_mf && sg_cfg[`RPS_B_SIG_STATE_FORMAT];
      done = 1'b0;
      setf = '0;
      clrf = '0;
      next_sg_abcd = sg_abcd;
      next_sg_last = sg_last;
      next_sg_acc = sg_acc;
      next_sg_snap = sg_snap;
      if (ch_ok && sync_ok) begin
        acc = sg_acc[ch];
        // 4-state repeats A and B in the second half of the multiframe
        unique case (s.frame)
          `RPS_FRM_6: acc[3] = s.sig_bit;
          `RPS_FRM_12: acc[2] = s.sig_bit;
          `RPS_FRM_18: if (sixteen) acc[1] = s.sig_bit; else acc[3] = s.sig_bit;
          `RPS_FRM_24: if (sixteen) acc[0] = s.sig_bit; else acc[2] = s.sig_bit;
          default: begin
          end
        endcase
        if (!sixteen) begin
          acc[1:0] = 2'h0;
        end
        next_sg_acc[ch] = acc;
        if (s.frame == `RPS_FRM_FIRST) begin
          next_sg_snap[ch] = sg_abcd[ch];
        end
        done = long_mf ? (s.frame == `RPS_FRM_24) : (s.frame == `RPS_FRM_12);
        if (done && !sg_cfg[`RPS_B_FREEZE] && sg_en[ch]) begin
          next_sg_last[ch] = acc;
          if (!sg_cfg[`RPS_B_DEB] || acc == sg_last[ch]) begin
            next_sg_abcd[ch] = acc;
            setf[ch] = acc != sg_abcd[ch];
          end
        end
      end
      if (wr && sel) begin
        unique case (addr[7:0])
          `RPS_OFF_CF0: clrf[7:0] = wdata;
          `RPS_OFF_CF1: clrf[15:8] = wdata;
          `RPS_OFF_CF2: clrf[23:16] = wdata;
          default: begin
          end
        endcase
      end
      // A change in the clearing cycle keeps its flag
      next_sig_change_flag = (sig_change_flag & ~clrf) | setf;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        sig_change_flag <= '0;
        for (int i = 0; i < `RPS_CHANS; i++) begin
          sg_abcd[i] <= 4'h0;
          sg_last[i] <= 4'h0;
          sg_acc[i] <= 4'h0;
          sg_snap[i] <= 4'h0;
        end
      end else begin
        sig_change_flag <= next_sig_change_flag;
        sg_abcd <= next_sg_abcd;
        sg_last <= next_sg_last;
        sg_acc <= next_sg_acc;
        sg_snap <= next_sg_snap;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // Receive payload control on the outgoing time slot
    // Everything here is one register stage deep, so the time slot leaves
    // exactly one cycle after it arrived whatever functions are active.
    always_comb begin
      logic [3:0] sg;
      logic [7:0] trk;
      logic [2:0] sub;
      logic [2:0] ph;
      sg = 4'h0;
      trk = 8'h00;
      sub = 3'h0;
      ph = 3'(s.frame - `RPS_FRM_FIRST);
      next_out.valid = s.valid;
      next_out.chan = s.chan;
      next_out.data = s.data;
      next_out.rx_sig_out = 4'h0;
      if (ch_ok) begin
        // Frame one outputs the live value while the lock is being taken
        if (pl_cfg[`RPS_B_SNAP] && sync_ok && s.frame != `RPS_FRM_FIRST) begin
          sg = sg_snap[ch];
        end else begin
          sg = sg_abcd[ch];
        end
        if (pl_ena[`RPS_B_PAYLOAD_CTRL_ENABLE]) begin
          trk = pl_mem[7'(ch) + `RPS_BASE_STRK];
          if (pl_cfg[`RPS_B_GTRK] || trk[`RPS_B_STRK]) begin
            sg = trk[3:0];
          end
          // Fixing overrides trunk conditioning
          if (pl_ena[`RPS_B_FIX] && sync_ok) begin
            sg = {4{pl_ena[`RPS_B_POL]}};
          end
          sub = (pl_cfg[2:0] != 3'h0) ? pl_cfg[2:0] : pl_mem[7'(ch)][7:5];
          unique case (sub)
            `RPS_SUB_DATA_TRUNK_CODE: next_out.data = pl_mem[7'(ch) + `RPS_BASE_DATA_TRUNK_CODE];
            `RPS_SUB_ALAW: next_out.data = rps_mw(1'b0, ph);
            `RPS_SUB_MULAW: next_out.data = rps_mw(1'b1, ph);
            default: begin
            end
          endcase
        end
        if (pl_ena[`RPS_B_SIG_POSITION_SEL] && long_mf) begin
          sg = {sg[3:2], 2'h0};
        end
        next_out.rx_sig_out = sg;
      end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        out_q <= '0;
      end else begin
        out_q <= next_out;
      end
    end

    assign sig_out[l] = out_q;
    assign link_irq[l] = sg_cfg[`RPS_B_SIG_CHANGE_IRQ_EN] && (|sig_change_flag);

    // Register read decode; reserved bits and holes read zero
    always_comb begin
      unique case (addr[7:0])
        `RPS_OFF_PL_STAT: link_rd[l] = {7'h00, pl_st == rps_pkg::RPS_BUSY};
        `RPS_OFF_PL_ACTL: link_rd[l] = pl_actl;
        `RPS_OFF_PL_DATA: link_rd[l] = pl_data;
        `RPS_OFF_PL_CFG: link_rd[l] = pl_cfg;
        `RPS_OFF_PL_ENA: link_rd[l] = pl_ena;
        `RPS_OFF_SG_CFG: link_rd[l] = sg_cfg;
        `RPS_OFF_SG_STAT: link_rd[l] = {7'h00, sg_st == rps_pkg::RPS_BUSY};
        `RPS_OFF_SG_ACTL: link_rd[l] = sg_actl;
        `RPS_OFF_SG_DATA: link_rd[l] = sg_data;
        `RPS_OFF_CF0: link_rd[l] = sig_change_flag[7:0];
        `RPS_OFF_CF1: link_rd[l] = sig_change_flag[15:8];
        `RPS_OFF_CF2: link_rd[l] = sig_change_flag[23:16];
        default: link_rd[l] = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data stand for one cycle only, zero otherwise
  assign next_rdata = rd ? link_rd[addr[9:8]] : 8'h00;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // Any link may raise the shared signaling interrupt
  // Software finds the source by polling the flag registers of each page.
  assign sig_irq = |link_irq;

endmodule

// >>> bench/rps_ctrl_sva.sv
`include "rps_regs.svh"
////////////////////////////////////////////////////////////
module rps_ctrl_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input rps_pkg::rps_sig_in_t sig_in [`RPS_LINKS],
  input rps_pkg::rps_sig_out_t sig_out [`RPS_LINKS],
  input wire logic sig_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  // Indirect start and status poll, one window each
  sequence pl_start;
    wr && addr[7:0] == `RPS_OFF_PL_ACTL;
  endsequence
  sequence sg_start;
    wr && addr[7:0] == `RPS_OFF_SG_ACTL;
  endsequence
  sequence poll(logic [7:0] off);
    rd && addr[7:0] == off && addr[9:8] == $past(addr[9:8]);
  endsequence
  pl_busy_a: assert property (pl_start ##1 poll(`RPS_OFF_PL_STAT) |=> rdata == 8'h01)
    else $error("payload busy missing");
  pl_idle_a: assert property (pl_start ##2 poll(`RPS_OFF_PL_STAT) |=> rdata == 8'h00)
    else $error("payload busy stuck");
  sg_busy_a: assert property (sg_start ##1 poll(`RPS_OFF_SG_STAT) |=> rdata == 8'h01)
    else $error("extract busy missing");
  // Read data lives one cycle only, so stale bytes cannot leak
  read_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside its cycle");
  unmapped_a: assert property (rd && addr[7:0] < `RPS_OFF_PL_STAT |=> rdata == 8'h00)
    else $error("unmapped offset returned data");
  ena_back_a: assert property (wr && addr[7:0] == `RPS_OFF_PL_ENA ##2 rd && $stable(addr)
    |=> rdata == ($past(wdata, 3) & `RPS_MSK_PL_ENA))
    else $error("control enable readback wrong");
  cfg_back_a: assert property (wr && addr[7:0] == `RPS_OFF_PL_CFG ##2 rd && $stable(addr)
    |=> rdata == ($past(wdata, 3) & `RPS_MSK_PL_CFG))
    else $error("payload config readback wrong");
  slot_pass_a: assert property (sig_in[0].valid
    |=> sig_out[0].valid && sig_out[0].chan == $past(sig_in[0].chan))
    else $error("slot lost");
  raw_chan_a: assert property (sig_in[1].valid && sig_in[1].chan >= 5'd24
    |=> sig_out[1].data == $past(sig_in[1].data) && sig_out[1].rx_sig_out == 4'h0)
    else $error("spare slot altered");
  no_slot_a: assert property (!sig_in[1].valid |=> !sig_out[1].valid)
    else $error("slot from nothing");
endmodule

// >>> bench/rps_ctrl_bench.sv
`include "rps_regs.svh"
////////////////////////////////////////////////////////////
module rps_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic sig_irq;
  rps_pkg::rps_sig_in_t sig_in [`RPS_LINKS];
  rps_pkg::rps_sig_out_t sig_out [`RPS_LINKS];
  rps_pkg::rps_sig_out_t o;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  logic [7:0] v;
  logic [7:0] d;
  logic [7:0] trk;
  logic [6:0] ias [8] = '{7'h01, 7'h18, 7'h21, 7'h38, 7'h41, 7'h58, 7'h19, 7'h60};
  logic [7:0] offs [3] = '{`RPS_OFF_PL_CFG, `RPS_OFF_PL_ENA, `RPS_OFF_SG_CFG};
  logic [7:0] msks [3] = '{`RPS_MSK_PL_CFG, `RPS_MSK_PL_ENA, `RPS_MSK_SG_CFG};

  rps_ctrl dut_u (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .sig_in(sig_in), .sig_out(sig_out), .sig_irq(sig_irq));

  // 50 ns period
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] pl_msk(input logic [6:0] a);
    // Table entries keep the whole byte; only holes read zero
    if (a >= `RPS_IA_LO0 && a <= `RPS_IA_HI0) return 8'hFF;
    if (a >= `RPS_IA_LO1 && a <= `RPS_IA_HI1) return 8'hFF;
    if (a >= `RPS_IA_LO2 && a <= `RPS_IA_HI2) return 8'hFF;
    return 8'h00;
  endfunction
  // Milliwatt byte for a frame, first frame takes the top byte
  function automatic logic [7:0] mw(input logic [63:0] p, input int fr);
    return p[63 - 8 * ((fr - 1) % 8) -: 8];
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [9:0] a, input logic [7:0] dv);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= dv;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [9:0] a, output logic [7:0] q);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  // Control write, busy poll, data read back to back; status sits below control
  task automatic ind(input logic [9:0] c, input logic [7:0] ctl, output logic [7:0] q);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= c;
    wdata <= ctl;
    @(posedge ref_clk);
    wr <= 1'b0;
    rd <= 1'b1;
    addr <= c - 10'h001;
    @(posedge ref_clk);
    addr <= c + 10'h001;
    #1 chk8(rdata, 8'h01);
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic slot(input int l, input logic [1:0] f, input logic [4:0] fr,
    input logic [4:0] ch, input logic sb);
    @(posedge ref_clk);
    d = 8'($urandom);
    sig_in[l] <= '{1'b1, 1'b1, f, fr, ch, d, sb};
    @(posedge ref_clk);
    sig_in[l].valid <= 1'b0;
    #1 o = sig_out[l];
  endtask
  // SF multiframe carrying A and B for one channel
  task automatic sf_word(input logic [4:0] ch, input logic a, input logic b);
    slot(0, `RPS_FMT_SF, `RPS_FRM_6, ch, a);
    slot(0, `RPS_FMT_SF, `RPS_FRM_12, ch, b);
  endtask
  task automatic print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int i = 0; i < `RPS_LINKS; i++) begin
      sig_in[i] = '0;
    end
    void'($urandom(32'h5B03));
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      rreg({p[1:0], `RPS_OFF_PL_CFG}, v);
      chk8(v, `RPS_RST_PL_CFG);
      rreg({p[1:0], `RPS_OFF_SG_CFG}, v);
      chk8(v, `RPS_RST_SG_CFG);
      rreg({p[1:0], 8'h00}, v);
      chk8(v, 8'h00);
    end
    for (int i = 0; i < 9; i++) begin
      d = 8'($urandom);
      wreg({2'h2, offs[i % 3]}, d);
      rreg({2'h2, offs[i % 3]}, v);
      chk8(v, d & msks[i % 3]);
    end
    rreg({2'h1, `RPS_OFF_PL_ENA}, v);
    chk8(v, `RPS_RST_PL_ENA);
    foreach (ias[i]) begin
      d = 8'($urandom);
      if (ias[i] == 7'h21) trk = d;
      wreg({2'h0, `RPS_OFF_PL_DATA}, d);
      ind({2'h0, `RPS_OFF_PL_ACTL}, {1'b0, ias[i]}, v);
      ind({2'h0, `RPS_OFF_PL_ACTL}, {1'b1, ias[i]}, v);
      chk8(v, d & pl_msk(ias[i]));
    end
    ind({2'h0, `RPS_OFF_SG_ACTL}, 8'h81, v);
    chk8(v, 8'h10);
    wreg({2'h0, `RPS_OFF_SG_DATA}, 8'h00);
    ind({2'h0, `RPS_OFF_SG_ACTL}, 8'h05, v);
    ind({2'h0, `RPS_OFF_SG_ACTL}, 8'h85, v);
    chk8(v, 8'h00);
    ind({2'h0, `RPS_OFF_SG_ACTL}, 8'h99, v);
    chk8(v, 8'h00);
    // Signaling change on channels 1, 9 and 17 of link 0
    wreg({2'h0, `RPS_OFF_SG_CFG}, 8'h03);
    #1 chk8({7'h00, sig_irq}, 8'h00);
    for (int c = 0; c < 24; c += 8) begin
      sf_word(5'(c), 1'b1, 1'b1);
    end
    #1 chk8({7'h00, sig_irq}, 8'h01);
    for (int k = 0; k < 3; k++) begin
      rreg({2'h0, `RPS_OFF_CF0 + 8'(k)}, v);
      chk8(v, 8'h01);
    end
    wreg({2'h0, `RPS_OFF_SG_CFG}, 8'h01);
    #1 chk8({7'h00, sig_irq}, 8'h00);
    wreg({2'h0, `RPS_OFF_CF0}, 8'h00);
    rreg({2'h0, `RPS_OFF_CF0}, v);
    chk8(v, 8'h01);
    for (int k = 0; k < 3; k++) begin
      wreg({2'h0, `RPS_OFF_CF0 + 8'(k)}, 8'h01);
    end
    wreg({2'h0, `RPS_OFF_SG_CFG}, 8'h03);
    rreg({2'h0, `RPS_OFF_CF0}, v);
    chk8(v, 8'h00);
    chk8({7'h00, sig_irq}, 8'h00);
    ind({2'h0, `RPS_OFF_SG_ACTL}, 8'h81, v);
    chk8(v, 8'h1C);
    // Freeze keeps the old word; de-bounce needs the same word twice
    wreg({2'h0, `RPS_OFF_SG_CFG}, 8'h0B);
    sf_word(5'd0, 1'b0, 1'b0);
    rreg({2'h0, `RPS_OFF_CF0}, v);
    chk8(v, 8'h00);
    wreg({2'h0, `RPS_OFF_SG_CFG}, 8'h07);
    sf_word(5'd0, 1'b0, 1'b1);
    rreg({2'h0, `RPS_OFF_CF0}, v);
    chk8(v, 8'h00);
    sf_word(5'd0, 1'b0, 1'b1);
    rreg({2'h0, `RPS_OFF_CF0}, v);
    chk8(v, 8'h01);
    // Payload substitution on channel 1 and signaling fix on channel 4
    wreg({2'h0, `RPS_OFF_PL_CFG}, 8'h01);
    slot(0, `RPS_FMT_SF, 5'd3, 5'd0, 1'b0);
    chk8(o.data, d);
    wreg({2'h0, `RPS_OFF_PL_ENA}, 8'h01);
    slot(0, `RPS_FMT_SF, 5'd3, 5'd0, 1'b0);
    chk8(o.data, trk);
    wreg({2'h0, `RPS_OFF_PL_CFG}, 8'h02);
    slot(0, `RPS_FMT_SF, 5'd4, 5'd0, 1'b0);
    chk8(o.data, mw(`RPS_PAT_ALAW, 4));
    wreg({2'h0, `RPS_OFF_PL_CFG}, 8'h03);
    slot(0, `RPS_FMT_SF, 5'd7, 5'd0, 1'b0);
    chk8(o.data, mw(`RPS_PAT_MULAW, 7));
    wreg({2'h0, `RPS_OFF_PL_ENA}, 8'h07);
    slot(0, `RPS_FMT_SF, 5'd2, 5'd3, 1'b0);
    chk8({4'h0, o.rx_sig_out}, 8'h0F);
    wreg({2'h0, `RPS_OFF_PL_ENA}, 8'h05);
    slot(0, `RPS_FMT_SF, 5'd2, 5'd3, 1'b1);
    chk8({4'h0, o.rx_sig_out}, 8'h00);
    // Per-channel trunk code on channel 1, then CD cleared below AB in ESF
    wreg({2'h0, `RPS_OFF_PL_DATA}, 8'h1A);
    ind({2'h0, `RPS_OFF_PL_ACTL}, 8'h41, v);
    wreg({2'h0, `RPS_OFF_PL_ENA}, 8'h01);
    slot(0, `RPS_FMT_SF, 5'd2, 5'd0, 1'b0);
    chk8({4'h0, o.rx_sig_out}, 8'h0A);
    wreg({2'h0, `RPS_OFF_PL_ENA}, 8'h09);
    slot(0, 2'h1, 5'd2, 5'd0, 1'b0);
    chk8({4'h0, o.rx_sig_out}, 8'h08);
    // Busy has dropped two cycles after the command
    wreg({2'h0, `RPS_OFF_PL_ACTL}, 8'h81);
    rreg({2'h0, `RPS_OFF_PL_STAT}, v);
    chk8(v, 8'h00);
    // Random slots on link 1, spare channels included
    repeat (40) begin
      slot(1, 2'($urandom), 5'($urandom), 5'($urandom), 1'($urandom));
    end
    print_verdict();
  end
endmodule

bind rps_ctrl rps_ctrl_sva chk_u (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .sig_in(sig_in), .sig_out(sig_out), .sig_irq(sig_irq));
